// File: hw/agtr_crc.sv
// Serial CRC engine that folds a snapshot of the register words, MSB first.
// Assumes start is a one-cycle pulse; a new start restarts the computation.
`timescale 1ns/1ps
module agtr_crc
  import agtr_pkg::*;
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  ce_i,
  input  wire logic                  start_i,
  input  wire logic [CRC_DATA_W-1:0] data_i,
  output logic      [15:0]           crc_o,
  output logic                       done_o
);

  typedef enum logic {CRC_IDLE, CRC_RUN} agtr_crc_state_type;

  agtr_crc_state_type    state;
  agtr_crc_state_type    next_state;
  logic [CRC_DATA_W-1:0] shreg;
  logic [CRC_DATA_W-1:0] next_shreg;
  logic [15:0]           crc;
  logic [15:0]           next_crc;
  logic [5:0]            bits;
  logic [5:0]            next_bits;
  logic                  done;
  logic                  next_done;
  logic                  fb;

  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_crc   = crc;
    next_bits  = bits;
    next_done  = 1'b0;
    fb         = crc[15] ^ shreg[CRC_DATA_W-1];
    if (start_i) begin
      next_state = CRC_RUN;
      next_shreg = data_i;
      next_crc   = CRC_INIT;
      next_bits  = 6'(CRC_DATA_W - 1);
    end else begin
      case (state)
        CRC_IDLE: begin
          next_state = CRC_IDLE;
        end
        CRC_RUN: begin
          next_crc   = {crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
          next_shreg = {shreg[CRC_DATA_W-2:0], 1'b0};
          next_bits  = bits - 6'h01;
          if (bits == 6'h00) begin
            next_state = CRC_IDLE;
            next_done  = 1'b1;
          end
        end
        default: begin
          next_state = CRC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state <= CRC_IDLE;
      shreg <= '0;
      crc   <= CRC_INIT;
      bits  <= 6'h00;
      done  <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      shreg <= next_shreg;
      crc   <= next_crc;
      bits  <= next_bits;
      done  <= next_done;
    end
  end

  assign crc_o  = crc;
  assign done_o = done;

endmodule

// File: hw/agtr_pkg.sv
// Constants, register map and frame layout for the gain trim register bank.
// Assumes a 16-bit register word and a fixed 32-bit serial frame per access.
package agtr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [5:0]  ADDR_GAIN_HIGH  = 6'h11;
  localparam logic [5:0]  ADDR_GAIN_LOW   = 6'h12;
  localparam logic [5:0]  ADDR_CHECKSUM   = 6'h3E;
  localparam logic [5:0]  ADDR_RSVD       = 6'h3F;

  localparam logic [15:0] GAIN_HIGH_RST   = 16'h8000;
  localparam logic [15:0] GAIN_LOW_RST    = 16'h0000;
  localparam logic [15:0] CHECKSUM_RST    = 16'h0000;
  localparam logic [15:0] RSVD_RST        = 16'h0000;
  localparam logic [15:0] RESP_RST        = 16'h0000;
  localparam logic [15:0] GAIN_LOW_MASK   = 16'hFF00;
  localparam int unsigned GAIN_LOW_MSB    = 15;
  localparam int unsigned GAIN_LOW_LSB    = 8;

  // ----------------------------------------------------------------
  // Serial frame
  // ----------------------------------------------------------------
  localparam logic [2:0]  OP_READ         = 3'h5;
  localparam logic [2:0]  OP_WRITE        = 3'h3;
  localparam logic [5:0]  FRAME_BITS      = 6'h20;
  localparam logic [5:0]  FRAME_LAST      = 6'h1F;
  localparam logic [5:0]  WORD_BITS       = 6'h10;
  localparam logic [5:0]  WORD_LAST       = 6'h0F;

  typedef struct packed {
    logic [2:0]  op;
    logic [5:0]  addr;
    logic [6:0]  count;
    logic [15:0] data;
  } agtr_frame_type;

  // ----------------------------------------------------------------
  // Checksum engine
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_POLY        = 16'h1021;
  localparam logic [15:0] CRC_INIT        = 16'hFFFF;
  localparam int unsigned CRC_DATA_W      = 48;

endpackage

// File: hw/agtr_sync.sv
// Two-flop level synchroniser, one pair of flops per bit.
// Assumes the inputs are quasi-static levels from another clock domain.
`timescale 1ns/1ps
module agtr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          stage1[gi] <= 1'b0;
          stage2[gi] <= 1'b0;
        end else if (ce_i) begin
          stage1[gi] <= async_i[gi];
          stage2[gi] <= stage1[gi];
        end
      end
    end
  endgenerate

  assign sync_o = stage2;

endmodule

// File: hw/agtr_top.sv
// Channel 1 gain trim, register-map checksum and reserved word behind a serial
// port, plus sample-period alignment from the sync/reset pin.
// Assumes the serial clock idles between frames and that chip select stays high
// for at least four system clock periods between frames.
//
// Behaviour
// - 16-bit read/write upper gain trim register
// - Lower register: upper byte writable, low byte zero
// - Upper resets to 8000h, lower to zero
// - Read-only map checksum, zero after reset
// - Data out released while chip select high
// - Sync pulse realigns the internal sample period
`timescale 1ns/1ps
module agtr_top
  import agtr_pkg::*;
#(
  parameter int unsigned SAMPLE_CNT_W  = 16,
  parameter int unsigned SAMPLE_PERIOD = 1024
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic        spi_sclk_i,
  input  wire logic        spi_cs_n_i,
  input  wire logic        spi_din_i,
  output logic             spi_dout_o,
  output logic             spi_dout_oe_n_o,
  input  wire logic        sync_reset_n_i,
  output logic             conversion_ready_n_o,
  output logic [23:0]      gain_trim_o
);

  // ----------------------------------------------------------------
  // Link reset
  // ----------------------------------------------------------------
  // Holds the link-side state cleared while the system is in reset.
  logic link_clear;
  logic frame_rst;

  always_ff @(posedge sys_clk_i) begin
    link_clear <= ~rstn_i;
  end

  assign frame_rst = spi_cs_n_i | link_clear;

  // ----------------------------------------------------------------
  // Link domain: frame receive
  // ----------------------------------------------------------------
  // Data in is sampled on the falling serial clock edge.
  logic [5:0]     bit_cnt;
  logic [5:0]     next_bit_cnt;
  logic [31:0]    shift_in;
  logic [31:0]    next_shift_in;
  logic           frame_end;
  agtr_frame_type frame_hold;
  agtr_frame_type next_frame_hold;
  logic           req_tog;
  logic           next_req_tog;

  always_comb begin
    next_bit_cnt  = bit_cnt;
    next_shift_in = shift_in;
    frame_end     = 1'b0;
    if (bit_cnt < FRAME_BITS) begin
      next_bit_cnt  = bit_cnt + 6'h01;
      next_shift_in = {shift_in[30:0], spi_din_i};
      frame_end     = (bit_cnt == FRAME_LAST);
    end
  end

  always_ff @(negedge spi_sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt  <= 6'h00;
      shift_in <= '0;
    end else begin
      bit_cnt  <= next_bit_cnt;
      shift_in <= next_shift_in;
    end
  end

  // The held frame is only replaced when a full frame arrives; a short frame is
  // dropped. One selected device per frame keeps the frame unambiguous.
  always_comb begin
    next_frame_hold = frame_hold;
    next_req_tog    = req_tog;
    if (frame_end) begin
      next_frame_hold = agtr_frame_type'(next_shift_in);
      next_req_tog    = ~req_tog;
    end
  end

  always_ff @(negedge spi_sclk_i or posedge link_clear) begin
    if (link_clear) begin
      frame_hold <= '0;
      req_tog    <= 1'b0;
    end else begin
      frame_hold <= next_frame_hold;
      req_tog    <= next_req_tog;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: data out
  // ----------------------------------------------------------------
  // The first word of each frame returns the answer of the previous frame.
  logic [15:0] resp;
  logic        dout;
  logic        next_dout;
  logic        dout_oe_n;
  logic        next_dout_oe_n;

  always_comb begin
    next_dout      = 1'b0;
    next_dout_oe_n = 1'b0;
    if (bit_cnt < WORD_BITS) begin
      next_dout = resp[4'(WORD_LAST - bit_cnt)];
    end
  end

  always_ff @(posedge spi_sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      dout      <= 1'b0;
      dout_oe_n <= 1'b1;
    end else begin
      dout      <= next_dout;
      dout_oe_n <= next_dout_oe_n;
    end
  end

  assign spi_dout_o      = dout;
  assign spi_dout_oe_n_o = dout_oe_n;

  // ----------------------------------------------------------------
  // Crossing into the system domain
  // ----------------------------------------------------------------
  logic [1:0] sync_in;
  logic [1:0] sync_out;
  logic       req_sync;
  logic       pin_sync_n;
  logic       req_seen;
  logic       pin_prev_n;
  logic       frame_event;
  logic       sync_fall;

  // The pin is synchronised inverted, so the flops' reset value matches its idle
  // level and no false sync edge restarts the sample period right after reset.
  assign sync_in = {~sync_reset_n_i, req_tog};

  agtr_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_i   (sys_clk_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .async_i (sync_in),
    .sync_o  (sync_out)
  );

  assign req_sync    = sync_out[0];
  assign pin_sync_n  = ~sync_out[1];
  assign frame_event = req_sync ^ req_seen;
  assign sync_fall   = pin_prev_n & ~pin_sync_n;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      req_seen   <= 1'b0;
      pin_prev_n <= 1'b1;
    end else if (ce_i) begin
      req_seen   <= req_sync;
      pin_prev_n <= pin_sync_n;
    end
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  logic [15:0]           gain_trim_upper_field;
  logic [15:0]           next_gain_trim_upper_field;
  logic [7:0]            gain_trim_lower_field;
  logic [7:0]            next_gain_trim_lower_field;
  logic [15:0]           rsvd;
  logic [15:0]           next_rsvd;
  logic [15:0]           map_checksum;
  logic [15:0]           next_map_checksum;
  logic [15:0]           next_resp;
  logic [15:0]           chan1_gain_trim_high;
  logic [15:0]           chan1_gain_trim_low;
  logic                  crc_start;
  logic [CRC_DATA_W-1:0] crc_data;
  logic [15:0]           crc_value;
  logic                  crc_done;

  assign chan1_gain_trim_high = gain_trim_upper_field;
  assign chan1_gain_trim_low  = {gain_trim_lower_field, 8'h00};

  always_comb begin
    next_gain_trim_upper_field = gain_trim_upper_field;
    next_gain_trim_lower_field = gain_trim_lower_field;
    next_rsvd                  = rsvd;
    next_map_checksum          = map_checksum;
    next_resp                  = resp;
    crc_start                  = 1'b0;
    if (crc_done) begin
      next_map_checksum = crc_value;
    end
    if (frame_event && frame_hold.op == OP_WRITE) begin
      next_resp = {frame_hold.op, frame_hold.addr, frame_hold.count};
      crc_start = 1'b1;
      case (frame_hold.addr)
        ADDR_GAIN_HIGH: begin
          next_gain_trim_upper_field = frame_hold.data;
        end
        ADDR_GAIN_LOW: begin
          next_gain_trim_lower_field = frame_hold.data[GAIN_LOW_MSB:GAIN_LOW_LSB];
        end
        ADDR_RSVD: begin
          next_rsvd = frame_hold.data;
        end
        default: begin
          crc_start = 1'b0;
        end
      endcase
    end else if (frame_event && frame_hold.op == OP_READ) begin
      case (frame_hold.addr)
        ADDR_GAIN_HIGH: begin
          next_resp = chan1_gain_trim_high;
        end
        ADDR_GAIN_LOW: begin
          next_resp = chan1_gain_trim_low & GAIN_LOW_MASK;
        end
        ADDR_CHECKSUM: begin
          next_resp = map_checksum;
        end
        ADDR_RSVD: begin
          next_resp = rsvd;
        end
        default: begin
          next_resp = RESP_RST;
        end
      endcase
    end else if (frame_event) begin
      next_resp = RESP_RST;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      gain_trim_upper_field <= GAIN_HIGH_RST;
      gain_trim_lower_field <= GAIN_LOW_RST[GAIN_LOW_MSB:GAIN_LOW_LSB];
      rsvd                  <= RSVD_RST;
      map_checksum          <= CHECKSUM_RST;
      resp                  <= RESP_RST;
    end else if (ce_i) begin
      gain_trim_upper_field <= next_gain_trim_upper_field;
      gain_trim_lower_field <= next_gain_trim_lower_field;
      rsvd                  <= next_rsvd;
      map_checksum          <= next_map_checksum;
      resp                  <= next_resp;
    end
  end

  // The checksum snapshot is taken from the values about to be stored.
  assign crc_data = {next_gain_trim_upper_field, next_gain_trim_lower_field, 8'h00, next_rsvd};

  agtr_crc u_crc (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .start_i   (crc_start),
    .data_i    (crc_data),
    .crc_o     (crc_value),
    .done_o    (crc_done)
  );

  assign gain_trim_o = {gain_trim_upper_field, gain_trim_lower_field};

  // ----------------------------------------------------------------
  // Sample period
  // ----------------------------------------------------------------
  // A sync falling edge restarts the period so that devices pulsed together
  // convert at the same instants.
  localparam logic [SAMPLE_CNT_W-1:0] PERIOD_LAST = SAMPLE_CNT_W'(SAMPLE_PERIOD - 1);

  logic [SAMPLE_CNT_W-1:0] sample_cnt;
  logic [SAMPLE_CNT_W-1:0] next_sample_cnt;
  logic                    ready_n;
  logic                    next_ready_n;

  always_comb begin
    next_sample_cnt = sample_cnt + SAMPLE_CNT_W'(1);
    next_ready_n    = 1'b1;
    if (sync_fall) begin
      next_sample_cnt = '0;
    end else if (sample_cnt == PERIOD_LAST) begin
      next_sample_cnt = '0;
      next_ready_n    = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      sample_cnt <= '0;
      ready_n    <= 1'b1;
    end else if (ce_i) begin
      sample_cnt <= next_sample_cnt;
      ready_n    <= next_ready_n;
    end
  end

  assign conversion_ready_n_o = ready_n;

endmodule

// File: verif/adc_gain_trim_crc_regs_and_bus_sharing_test.sv
// Testbench for the gain trim bank: register access over the serial port and sync timing.
// Assumes agtr_host_model as the host and the checker bound to the top module.
`timescale 1ns/1ps
module adc_gain_trim_crc_regs_and_bus_sharing_test
  import agtr_pkg::*;
;
  localparam int unsigned PERIOD = 8;
  logic             sys_clk_i;
  logic             rstn_i;
  logic             sync_reset_n_i;
  wire logic        sclk;
  wire logic        cs_n;
  wire logic        din;
  wire logic        dout;
  wire logic        dout_oe_n;
  wire logic        ready_n;
  wire logic [23:0] trim;
  int               num_errors = 0;
  int               checks = 0;
  int               n;
  logic [15:0]      rsp;
  logic [15:0]      hv [3] = '{16'hA5C3, 16'hFFFF, 16'h0001};
  logic [15:0]      lv [3] = '{16'h7E5A, 16'hFFFF, 16'h00FF};

  agtr_top #(.SAMPLE_CNT_W(16), .SAMPLE_PERIOD(PERIOD)) uut (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_din_i(din), .spi_dout_o(dout), .spi_dout_oe_n_o(dout_oe_n), .sync_reset_n_i(sync_reset_n_i),
    .conversion_ready_n_o(ready_n), .gain_trim_o(trim));
  agtr_host_model host (.spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_din_o(din), .spi_dout_i(dout),
    .spi_dout_oe_n_i(dout_oe_n));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] addr, input logic [15:0] data, input int nbits = 32);
    agtr_frame_type f;
    logic [15:0]    rx;
    f = '{OP_WRITE, addr, 7'h00, data};
    @(negedge sys_clk_i);
    host.frame(f, nbits, rx);
  endtask

  // The answer to a read comes back in the first word of the following frame.
  task automatic rdc(input logic [5:0] addr, input logic [15:0] exp);
    agtr_frame_type f;
    logic [15:0]    rx;
    f = '{OP_READ, addr, 7'h00, 16'h0000};
    @(negedge sys_clk_i);
    host.frame(f, 32, rx);
    @(negedge sys_clk_i);
    host.frame(f, 32, rx);
    check(rx, exp);
  endtask

  function automatic logic [15:0] crc16(input logic [47:0] d);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 47; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    #200000;
    num_errors++;
    end_sim;
  end

  initial begin
    rstn_i = 1'b0;
    sync_reset_n_i = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    check(trim, 24'h800000);
    check(dout_oe_n, 1'b1);
    rdc(ADDR_GAIN_HIGH, GAIN_HIGH_RST);
    rdc(ADDR_GAIN_LOW, GAIN_LOW_RST);
    rdc(ADDR_CHECKSUM, CHECKSUM_RST);
    rdc(ADDR_RSVD, RSVD_RST);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_GAIN_HIGH, hv[i]);
      wr(ADDR_GAIN_LOW, lv[i]);
      rdc(ADDR_GAIN_HIGH, hv[i]);
      rdc(ADDR_GAIN_LOW, lv[i] & GAIN_LOW_MASK);
      check(trim, {hv[i], lv[i][15:8]});
    end
    wr(ADDR_GAIN_HIGH, 16'h1234, 31);
    rdc(ADDR_GAIN_HIGH, 16'h0001);
    check(dout_oe_n, 1'b1);
    wr(ADDR_RSVD, 16'h0000);
    // A write answers with its own command word; an unknown op code answers zero.
    @(negedge sys_clk_i);
    host.frame({3'h0, ADDR_GAIN_HIGH, 7'h00, 16'h0000}, 32, rsp);
    check(rsp, {OP_WRITE, ADDR_RSVD, 7'h00});
    @(negedge sys_clk_i);
    host.frame({OP_READ, 6'h20, 7'h00, 16'h0000}, 32, rsp);
    check(rsp, RESP_RST);
    wr(ADDR_CHECKSUM, 16'h5A5A);
    repeat (60) @(negedge sys_clk_i);
    rdc(ADDR_CHECKSUM, crc16({16'h0001, 16'h0000, 16'h0000}));
    n = 0;
    while (ready_n !== 1'b0 && n < 100) begin
      @(negedge sys_clk_i);
      n++;
    end
    repeat (3) @(negedge sys_clk_i);
    sync_reset_n_i = 1'b0;
    n = 0;
    while (ready_n !== 1'b0 && n < 100) begin
      @(negedge sys_clk_i);
      n++;
      if (n == 3) sync_reset_n_i = 1'b1;
    end
    check(n >= PERIOD + 1 && n <= PERIOD + 4, 1'b1);
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (ready_n !== 1'b0 && n < 100);
    check(n, PERIOD);
    end_sim;
  end
endmodule

bind agtr_top agtr_checker #(.SAMPLE_PERIOD(SAMPLE_PERIOD)) u_chk (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .spi_cs_n_i(spi_cs_n_i), .spi_dout_o(spi_dout_o),
  .spi_dout_oe_n_o(spi_dout_oe_n_o), .sync_reset_n_i(sync_reset_n_i),
  .conversion_ready_n_o(conversion_ready_n_o), .gain_trim_o(gain_trim_o));

// File: verif/agtr_assertions.sv
// Checker for the gain trim bank: data-out release, trim output and ready timing.
// Assumes it is bound to agtr_top and sees only that module's ports.
`timescale 1ns/1ps
module agtr_checker
  import agtr_pkg::*;
#(
  parameter int unsigned SAMPLE_PERIOD = 1024
) (
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  input wire logic        spi_cs_n_i,
  input wire logic        spi_dout_o,
  input wire logic        spi_dout_oe_n_o,
  input wire logic        sync_reset_n_i,
  input wire logic        conversion_ready_n_o,
  input wire logic [23:0] gain_trim_o
);
  localparam int SYNC_LO = SAMPLE_PERIOD + 1;
  localparam int SYNC_HI = SAMPLE_PERIOD + 4;
  int   gap;
  int   quiet;
  int   cs_hi;
  logic armed;
  int   next_gap;
  int   next_quiet;
  int   next_cs_hi;
  logic next_armed;

  // ----------------------------------------------------------------
  // Cycle counters
  // ----------------------------------------------------------------
  always_comb begin
    next_gap   = conversion_ready_n_o ? gap + 1 : 1;
    next_quiet = sync_reset_n_i ? ((quiet < 100000) ? quiet + 1 : quiet) : 0;
    next_cs_hi = spi_cs_n_i ? ((cs_hi < 1000) ? cs_hi + 1 : cs_hi) : 0;
    next_armed = armed | !conversion_ready_n_o;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      gap   <= 0;
      quiet <= 0;
      cs_hi <= 0;
      armed <= 1'b0;
    end else begin
      gap   <= next_gap;
      quiet <= next_quiet;
      cs_hi <= next_cs_hi;
      armed <= next_armed;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_sync_fall;
    $fell(sync_reset_n_i);
  endsequence
  sequence s_ready_pulse;
    !conversion_ready_n_o ##1 conversion_ready_n_o;
  endsequence

  a_dout_hiz_deselect: assert property (disable iff (1'b0) spi_cs_n_i |-> spi_dout_oe_n_o)
    else $error("data out enabled while deselected");
  a_dout_quiet_idle: assert property (spi_cs_n_i [*2] |-> !spi_dout_o)
    else $error("data out not idle while deselected");
  a_trim_reset_value: assert property (disable iff (1'b0) !rstn_i |=> gain_trim_o == {GAIN_HIGH_RST, 8'h00})
    else $error("trim output not at reset value");
  a_trim_steady_idle: assert property (cs_hi > 6 |-> $stable(gain_trim_o))
    else $error("trim output changed without a frame");
  a_ready_reset_high: assert property (disable iff (1'b0) !rstn_i |=> conversion_ready_n_o)
    else $error("ready asserted during reset");
  a_ready_one_cycle: assert property (!conversion_ready_n_o |=> conversion_ready_n_o)
    else $error("ready pulse longer than one cycle");
  a_ready_period_exact: assert property (!conversion_ready_n_o && armed && quiet > SYNC_HI + 2
                                         |-> gap == SAMPLE_PERIOD)
    else $error("ready pulses not one sample period apart");
  a_sync_align_period: assert property (s_sync_fall |-> ##[SYNC_LO:SYNC_HI] s_ready_pulse)
    else $error("sync pulse did not realign the sample period");
endmodule

// File: verif/agtr_host_model.sv
// Host model: drives chip select, serial clock and data in, reads data out.
// Assumes a lone device on this select line and a 32 ns serial clock period.
`timescale 1ns/1ps
module agtr_host_model (
  output logic      spi_sclk_o,
  output logic      spi_cs_n_o,
  output logic      spi_din_o,
  input  wire logic spi_dout_i,
  input  wire logic spi_dout_oe_n_i
);
  logic last_dout;
  logic miso;

  // A released data-out line shows the inverse of its last driven level.
  always @(*) if (!spi_dout_oe_n_i) last_dout = spi_dout_i;
  assign miso = spi_dout_oe_n_i ? ~last_dout : spi_dout_i;

  initial begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_din_o  = 1'b1;
  end

  // Serial clock runs only inside a frame; data changes on rising edges.
  task automatic frame(input logic [31:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    spi_cs_n_o = 1'b0;
    #16;
    for (int i = 0; i < nbits; i++) begin
      spi_sclk_o = 1'b1;
      spi_din_o  = tx[31-i];
      #16;
      spi_sclk_o = 1'b0;
      if (i < 16) rx[15-i] = miso;
      #16;
    end
    spi_cs_n_o = 1'b1;
    spi_din_o  = ~spi_din_o;
    #250;
  endtask
endmodule
